// ---- bench/brp_host_model.sv ----
// Host model issuing reads to the pointer.
// Assumes strobes are sampled on the rising clock edge.
`timescale 1ns/1ns
module brp_host_model
    import brp_pkg::*;
(
    input  wire logic  ref_clk,
    output logic       xfer_start,
    output logic       addr_load,
    output logic [6:0] addr_value,
    output logic       burst_req,
    output logic       byte_read,
    output logic       xfer_end
);
    // Idle strobes low; unused address shows the inverse of the last one
    initial {xfer_start, addr_load, burst_req, byte_read, xfer_end, addr_value} = 12'h02a;
    // Start address always supplied, as the four-wire port never rewinds
    task automatic access(input logic [6:0] a, input int n, input logic b);
        @(negedge ref_clk);
        {xfer_start, addr_load, burst_req, addr_value} = {2'b11, b, a};
        @(negedge ref_clk);
        {xfer_start, addr_load, addr_value} = {2'b00, ~a};
        repeat (n) begin
            byte_read = 1'b1;
            @(negedge ref_clk);
            byte_read = 1'b0;
            @(negedge ref_clk);
        end
        xfer_end = 1'b1;
        @(negedge ref_clk);
        xfer_end = 1'b0;
    endtask
endmodule

// ---- bench/brp_pointer_checker.sv ----
// Port assertions for brp_pointer.
// Assumes one clock domain; bound to every brp_pointer.
`timescale 1ns/1ns
module brp_pointer_checker
    import brp_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       spi_mode,
    input wire logic       i2c_stop_pin,
    input wire logic       xfer_start,
    input wire logic       burst_req,
    input wire logic       xfer_end,
    input wire logic       byte_read,
    input wire logic       addr_load,
    input wire logic [1:0] fifo_mode,
    input wire logic       fast_read,
    input wire logic [7:0] sample_ready_status,
    input wire logic [7:0] rd_data,
    input wire logic       rd_valid,
    input wire logic [6:0] reg_addr,
    input wire logic       burst_active
);
    // Hold checks use spi_mode so a late stop cannot move the pointer
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_reset_clear: assert property (disable iff (1'b0) rst |=> reg_addr == PTR_RESET && rd_data == STATUS_RESET)
        else $error("reset values wrong");
    a_burst_flag: assert property (xfer_start && burst_req && !burst_active |=> burst_active)
        else $error("burst flag not raised");
    a_burst_end: assert property (xfer_end && !xfer_start |=> !burst_active)
        else $error("burst flag not cleared");
    a_read_answer: assert property (rd_valid == $past(byte_read)) else $error("read answer late");
    a_single_hold: assert property (spi_mode && byte_read && !burst_active && !addr_load |=> $stable(reg_addr))
        else $error("single read moved pointer");
    a_upper_step: assert property (spi_mode && burst_active && byte_read && !addr_load && fifo_mode == FMODE_OFF
        && fast_read && reg_addr inside {[ADDR_UPPER_FIRST:ADDR_UPPER_LAST]} |=> reg_addr == $past(reg_addr) + 7'h01)
        else $error("upper row step wrong");
    a_spi_keep: assert property (spi_mode && !addr_load && !byte_read |=> $stable(reg_addr))
        else $error("pointer moved on its own");
    a_stop_rewind: assert property (!spi_mode && $rose(i2c_stop_pin) |-> ##[1:8] reg_addr == ADDR_STATUS)
        else $error("stop did not rewind");
    a_status_alias: assert property (byte_read && reg_addr == ADDR_STATUS && fifo_mode == FMODE_OFF
        |=> rd_data == $past(sample_ready_status, 2)) else $error("status alias wrong");
endmodule
bind brp_pointer brp_pointer_checker i_chk (.ref_clk, .rst, .spi_mode, .i2c_stop_pin, .xfer_start, .burst_req,
    .xfer_end, .byte_read, .addr_load,
    .fifo_mode, .fast_read, .sample_ready_status, .rd_data, .rd_valid, .reg_addr, .burst_active);

// ---- bench/burst_read_address_pointer_test.sv ----
// Self-checking bench for brp_pointer.
// Assumes the host model drives strobes; the bench drives the rest.
`timescale 1ns/1ns
module burst_read_address_pointer_test
    import brp_pkg::*;
;
    logic ref_clk = 1'b0, rst = 1'b1, spi_mode = 1'b1, i2c_stop_pin = 1'b0, fast_read = 1'b1, b;
    logic [1:0] fifo_mode = 2'h0;
    logic [7:0] sample_ready_status = 8'h00, fifo_status = 8'h00, reg_rdata = 8'h00, rd_data;
    logic xfer_start, addr_load, burst_req, byte_read, xfer_end, rd_valid, burst_active;
    logic [6:0] addr_value, reg_addr, a;
    int n, n_errors = 0, samples_checked = 0;
    // 10 MHz reference
    always #50 ref_clk = ~ref_clk;
    brp_host_model i_host (.ref_clk, .xfer_start, .addr_load, .addr_value, .burst_req, .byte_read, .xfer_end);
    brp_pointer i_dut (.ref_clk, .rst, .spi_mode, .i2c_stop_pin, .xfer_start, .addr_load, .addr_value, .burst_req,
        .byte_read, .xfer_end, .fifo_mode, .fast_read, .sample_ready_status, .fifo_status, .reg_rdata, .reg_addr,
        .rd_data, .rd_valid, .burst_active);
    // Pointer after n reads; upper rows step only with fast read and no FIFO
    function automatic logic [6:0] step(logic [6:0] p, int k, logic bu);
        for (int i = 0; i < k; i++)
            if (bu && p != ADDR_RESERVED && (p < ADDR_UPPER_FIRST || (fifo_mode == FMODE_OFF && fast_read)))
                p = p + 7'h01;
        return p;
    endfunction
    task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic complete_run();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(7));
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        chk("reset ptr", {1'b0, PTR_RESET}, {1'b0, reg_addr});
        chk("reset data", STATUS_RESET, rd_data);
        // Random singles and bursts through the upper rows, last read at or below 0x78
        repeat (40) begin
            {fifo_mode, fast_read, b, reg_rdata} = 12'($urandom);
            a = 7'($urandom_range(8'h66, 8'h78));
            n = $urandom_range(1, 4);
            if (n > int'(ADDR_RESERVED) - int'(a))
                n = int'(ADDR_RESERVED) - int'(a);
            i_host.access(a, n, b);
            chk("ptr", {1'b0, step(a, n, b)}, {1'b0, reg_addr});
            chk("data", reg_rdata, rd_data);
        end
        // Status alias in every mode, then the byte after it
        for (int m = 0; m < 4; m++) begin
            fifo_mode = 2'(m);
            {sample_ready_status, fifo_status, reg_rdata} = 24'($urandom);
            i_host.access(ADDR_STATUS, 1, 1'b1);
            chk("status", m == 0 ? sample_ready_status : fifo_status, rd_data);
            i_host.access(ADDR_STATUS, 2, 1'b1);
            chk("next byte", reg_rdata, rd_data);
        end
        // Stop rewinds only on the two-wire port
        fifo_mode = FMODE_OFF;
        fast_read = 1'b1;
        for (int s = 0; s < 2; s++) begin
            spi_mode = 1'(s);
            i_host.access(7'h70, 2, 1'b1);
            i2c_stop_pin = 1'b1;
            repeat (8) @(negedge ref_clk);
            i2c_stop_pin = 1'b0;
            chk("stop ptr", s ? 8'h72 : 8'h00, {1'b0, reg_addr});
        end
        complete_run();
    end
endmodule

// ---- core/brp_pointer.sv ----
// Burst-read register address pointer with status alias at 0x00.
// Assumes a serial slave front end on ref_clk that delivers start, address
// and byte-read strobes; the stop condition arrives as an asynchronous pin.
// Functional notes
// - Pointer advances only during burst reads.
// - I2C stop returns pointer to 0x00.
// - SPI never resets pointer; host sets start.
// - Address 0x00 aliases sample or FIFO status.
// - Burst from 0x00 continues into sample data.
// - Status is eight bits, read-only, reset zero.
// - Fast read with FIFO off steps 0x68..0x78 to next address.
`timescale 1ns/1ns
module brp_pointer
    import brp_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       spi_mode,
    input  wire logic       i2c_stop_pin,
    input  wire logic       xfer_start,
    input  wire logic       addr_load,
    input  wire logic [6:0] addr_value,
    input  wire logic       burst_req,
    input  wire logic       byte_read,
    input  wire logic       xfer_end,
    input  wire logic [1:0] fifo_mode,
    input  wire logic       fast_read,
    input  wire logic [7:0] sample_ready_status,
    input  wire logic [7:0] fifo_status,
    input  wire logic [7:0] reg_rdata,
    output logic [6:0]      reg_addr,
    output logic [7:0]      rd_data,
    output logic            rd_valid,
    output logic            burst_active
);
    brp_state_t state_r;
    brp_state_t state_nxt;
    logic [6:0] ptr_r;
    logic [6:0] ptr_nxt;
    logic [6:0] ptr_step;
    logic       in_burst;
    logic       in_upper;
    logic       at_reserved;
    logic       upper_step_ok;
    logic       step_en;
    logic       stop_lvl;
    logic       stop_prev_r;
    logic       stop_evt;
    logic       status_pick_fifo;
    logic [7:0] status_sel;
    logic [7:0] status_r;
    logic [7:0] rdata_sel;

    // Stop pin comes from outside the clock domain; the
    // synchroniser costs a few cycles but keeps metastability out
    brp_sync u_stop_sync (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .pin_in    (i2c_stop_pin),
        .level_out (stop_lvl)
    );

    // Previous filtered stop level; reset matches the idle pin
    // level so no false stop follows reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stop_prev_r <= 1'b0;
        end else begin
            stop_prev_r <= stop_lvl;
        end
    end

    // Stop counts on its rising edge, two-wire port only; the
    // four-wire port has no stop, so the host must reload the start
    assign stop_evt = stop_lvl & ~stop_prev_r & ~spi_mode;

    // Transfer kind tracking; the kind is fixed at the start so a
    // late burst_req change cannot switch stepping on mid-access
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BRP_IDLE: begin
                if (xfer_start) begin
                    if (burst_req) begin
                        state_nxt = BRP_BURST;
                    end else begin
                        state_nxt = BRP_SINGLE;
                    end
                end
            end
            BRP_SINGLE: begin
                if (xfer_end || stop_evt) begin
                    state_nxt = BRP_IDLE;
                end
            end
            BRP_BURST: begin
                if (xfer_end || stop_evt) begin
                    state_nxt = BRP_IDLE;
                end
            end
            default: begin
                state_nxt = BRP_IDLE;
            end
        endcase
    end

    // Transfer kind register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= BRP_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Only a burst may step the pointer
    assign in_burst = (state_r == BRP_BURST);

    // Window decode for the stepped upper rows and the reserved slot
    assign in_upper    = (ptr_r >= ADDR_UPPER_FIRST) && (ptr_r <= ADDR_UPPER_LAST);
    assign at_reserved = (ptr_r == ADDR_RESERVED);

    // Upper rows step only in the FIFO-off, fast-read column; other
    // columns belong to the wider map and simply hold here
    assign upper_step_ok = (fifo_mode == FMODE_OFF) && fast_read;

    // Successor address; rows outside the window, except the reserved slot, count up by one
    always_comb begin
        ptr_step = ptr_r + 7'h01;
        if (in_upper && !upper_step_ok) begin
            ptr_step = ptr_r;
        end
        if (at_reserved) begin
            ptr_step = ptr_r; // Reserved slot has no successor
        end
    end

    // Step only on a byte read inside a burst; single accesses
    // leave the pointer where the host put it
    assign step_en = byte_read && in_burst;

    // Pointer update; stop wins over everything since it ends the frame
    always_comb begin
        ptr_nxt = ptr_r;
        if (stop_evt) begin
            ptr_nxt = ADDR_STATUS;
        end else if (addr_load) begin
            ptr_nxt = addr_value;
        end else if (step_en) begin
            ptr_nxt = ptr_step;
        end
    end

    // Pointer register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ptr_r <= PTR_RESET;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    // Alias select; any non-zero mode hands 0x00 to the FIFO
    assign status_pick_fifo = (fifo_mode != FMODE_OFF);
    always_comb begin
        if (status_pick_fifo) begin
            status_sel = fifo_status;
        end else begin
            status_sel = sample_ready_status;
        end
    end

    // Registered status copy, zero after reset, never written by host
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_r <= STATUS_RESET;
        end else begin
            status_r <= status_sel;
        end
    end

    // Byte source: status at 0x00, else the register file, so a
    // burst from 0x00 runs straight on into the sample bytes
    always_comb begin
        if (ptr_r == ADDR_STATUS) begin
            rdata_sel = status_r;
        end else begin
            rdata_sel = reg_rdata;
        end
    end

    // Read data holds until the next byte read
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_data <= DATA_RESET;
        end else if (byte_read) begin
            rd_data <= rdata_sel;
        end
    end

    // One-cycle strobe beside each returned byte
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= byte_read;
        end
    end

    // Port copy of the pointer, taken from the next value so the
    // port equals the internal pointer after every edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_addr <= PTR_RESET;
        end else begin
            reg_addr <= ptr_nxt;
        end
    end

    // Burst flag, registered the same way
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            burst_active <= 1'b0;
        end else begin
            burst_active <= (state_nxt == BRP_BURST);
        end
    end
endmodule

// ---- core/brp_sync.sv ----
// Three-stage synchroniser with agreement filter for the stop pin.
// Assumes the input is asynchronous to ref_clk.
`timescale 1ns/1ns
module brp_sync
    import brp_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level_out
);
    logic [SYNC_STAGES-1:0] stage_r;

    // Shift chain; first stage feeds only the second
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage_r <= '0;
        end else begin
            stage_r <= {stage_r[SYNC_STAGES-2:0], pin_in};
        end
    end

    // Accept a change only when stages two and three agree
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            level_out <= 1'b0;
        end else if (stage_r[1] == stage_r[2]) begin
            level_out <= stage_r[2];
        end
    end
endmodule

// ---- pkg/brp_pkg.sv ----
// Package for the burst-read address pointer block.
// Assumes a byte-wide serial slave front end that reports transaction events.
package brp_pkg;
    localparam logic [6:0] ADDR_STATUS      = 7'h00; // Status alias location
    localparam logic [6:0] ADDR_UPPER_FIRST = 7'h68; // First stepped upper address
    localparam logic [6:0] ADDR_UPPER_LAST  = 7'h78; // Last defined upper address
    localparam logic [6:0] ADDR_RESERVED    = 7'h79; // Reserved, no successor
    localparam logic [7:0] STATUS_RESET     = 8'h00; // Status after reset
    localparam logic [1:0] FMODE_OFF        = 2'h0;  // FIFO disabled mode
    localparam logic [6:0] PTR_RESET        = 7'h00; // Pointer after reset
    localparam logic [7:0] DATA_RESET       = 8'h00; // Read data after reset
    localparam int         SYNC_STAGES      = 3;     // Pin synchroniser depth

    typedef enum logic [2:0] {
        BRP_IDLE   = 3'b001,
        BRP_SINGLE = 3'b010,
        BRP_BURST  = 3'b100
    } brp_state_t;
endpackage
